// ### design/gpcfg_pkg.sv
// Package of constants for the port pin configuration block
// Function
// - Per-pin open-drain select beside direction and latch
// - Open-drain pins drive low only, else release
// - Analog select registers reset to all ones
// - Analog output pin level still reaches analog peripherals on push-pull pins; open-drain ones send zero
// - Pin level reads zero on analog input pins
package gpcfg_pkg;
    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam int          GPCFG_W        = 16;       // Pins per port
    localparam logic [11:0] GPCFG_OFF_DIR  = 12'h000;  // direction_select
    localparam logic [11:0] GPCFG_OFF_LVL  = 12'h004;  // pin_level_register
    localparam logic [11:0] GPCFG_OFF_LAT  = 12'h008;  // output_latch
    localparam logic [11:0] GPCFG_OFF_ODS  = 12'h00C;  // open_drain_select
    localparam logic [11:0] GPCFG_OFF_ANS  = 12'h010;  // analog_select
    localparam logic [15:0] GPCFG_RST_DIR  = 16'hFFFF; // Pins start as inputs
    localparam logic [15:0] GPCFG_RST_LAT  = 16'h0000;
    localparam logic [15:0] GPCFG_RST_ODS  = 16'h0000;
    localparam logic [15:0] GPCFG_RST_ANS  = 16'hFFFF;
endpackage

// ### design/gpcfg_pin.sv
// One port pin: output driver and digital input sampling
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pin
    import gpcfg_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic dir_in,      // 1 = input
    input  wire logic lat,         // Output latch bit
    input  wire logic ods,         // Open-drain select bit
    input  wire logic ans,         // Analog select bit
    input  wire logic pin_i,       // Pad level
    output logic      pin_o_q,     // Pad output value
    output logic      pin_oe_q,    // Pad output enable, high while driving
    output logic      ana_lvl_q,   // Driven level toward analog peripherals
    output logic      lvl_q        // Sampled level for reads
);
    // ****************************************
    // Driver
    // ****************************************
    wire drv_en = !dir_in && (!ods || !lat);
    wire drv_v  = ods ? 1'b0 : lat;
    wire rd_v   = (ans && dir_in) ? 1'b0 : pin_i;

    // Registered pad drive and read level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_o_q   <= 1'b0;
            pin_oe_q  <= 1'b0;
            ana_lvl_q <= 1'b0;
            lvl_q     <= 1'b0;
        end
        else
        begin
            pin_o_q   <= drv_v;
            pin_oe_q  <= drv_en;
            ana_lvl_q <= (ans && !dir_in) ? drv_v : 1'b0;
            lvl_q     <= rd_v;
        end
    end

    // Open drain never drives high
    od_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ods) && $past(!dir_in) && $past(lat)) |-> !pin_oe_q)
        else $error("open drain pin drove high");
    // Input pins never driven
    in_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(dir_in) |-> !pin_oe_q)
        else $error("input pin driven");
    // Analog input reads low
    ana_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ans) && $past(dir_in)) |-> !lvl_q)
        else $error("analog input read high");
    // Analog peripheral sees driven level
    ana_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ans) && !$past(dir_in) && !$past(ods)) |-> ana_lvl_q == $past(lat))
        else $error("analog level wrong");
endmodule
`default_nettype wire

// ### design/gpcfg_top.sv
// Port pin configuration block with APB register access
`timescale 1ns/1ps
`default_nettype none
module gpcfg_top
    import gpcfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] pin_i,       // Pad levels
    output logic      [15:0] pin_o,       // Pad output values
    output logic      [15:0] pin_oe,      // Pad output enables
    output logic      [15:0] ana_lvl,     // Levels routed to analog peripherals
    output logic      [15:0] ana_sel      // Analog mode per pin
);
    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] dir_q;      // direction_select, 1 = input
    logic [15:0] lat_q;      // output_latch
    logic [15:0] ods_q;      // open_drain_select
    logic [15:0] ans_q;      // analog_select
    logic [15:0] lvl;        // Sampled pin levels
    logic [31:0] prdata_q;   // Read data, held through the access phase
    logic        pslverr_q;  // Error answer, held like the read data
    logic        pready_q;   // Ready, low from reset until the first edge after it

    // ****************************************
    // Decode
    // ****************************************
    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire hit_dir = paddr == GPCFG_OFF_DIR;
    wire hit_lvl = paddr == GPCFG_OFF_LVL;
    wire hit_lat = paddr == GPCFG_OFF_LAT;
    wire hit_ods = paddr == GPCFG_OFF_ODS;
    wire hit_ans = paddr == GPCFG_OFF_ANS;
    wire hit_any = hit_dir || hit_lvl || hit_lat || hit_ods || hit_ans;
    // Writing the level register writes the latch, as on a port
    wire [15:0] rd_mux = hit_dir ? dir_q :
                         hit_lvl ? lvl   :
                         hit_lat ? lat_q :
                         hit_ods ? ods_q :
                         hit_ans ? ans_q : 16'h0000;

    // ****************************************
    // Write enables and next values
    // ****************************************
    // One enable per register; a write to the level register lands in the latch
    wire        we_dir = wr && hit_dir;
    wire        we_lat = wr && (hit_lat || hit_lvl);
    wire        we_ods = wr && hit_ods;
    wire        we_ans = wr && hit_ans;
    // Only the low half of the bus word is stored, upper bits dropped on purpose
    wire [15:0] dir_d  = pwdata[15:0];
    wire [15:0] lat_d  = pwdata[15:0];
    wire [15:0] ods_d  = pwdata[15:0];
    wire [15:0] ans_d  = pwdata[15:0];

    // Direction register; pins come up as inputs so nothing is driven at power-up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_q <= GPCFG_RST_DIR;
        end
        else if (we_dir)
        begin
            dir_q <= dir_d;
        end
    end

    // Output latch; it only reaches a pad while that pin is an output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lat_q <= GPCFG_RST_LAT;
        end
        else if (we_lat)
        begin
            lat_q <= lat_d;
        end
    end

    // Open-drain select; cleared at reset so outputs start push-pull
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ods_q <= GPCFG_RST_ODS;
        end
        else if (we_ods)
        begin
            ods_q <= ods_d;
        end
    end

    // Analog select; every shared pin starts in analog mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ans_q <= GPCFG_RST_ANS;
        end
        else if (we_ans)
        begin
            ans_q <= ans_d;
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************
    // Read data captured at setup, so it already stands in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
        end
        else if (psel && !penable)
        begin
            prdata_q <= {16'h0000, rd_mux};
        end
    end

    // Error flag captured beside the read data for unmapped offsets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_q <= !hit_any;
        end
    end

    // Ready rises on the first edge after reset and then stays high;
    // zero wait states keep the bus simple at the cost of a captured read mux
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= 1'b1;
        end
    end

    // Every bus output comes straight from a flip-flop
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ana_sel follows the register directly
    assign ana_sel = ans_q;

    // ****************************************
    // Pin slices
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < GPCFG_W; gi++)
        begin : g_pin
            gpcfg_pin u_pin (
                .pclk      (pclk),
                .presetn   (presetn),
                .dir_in    (dir_q[gi]),
                .lat       (lat_q[gi]),
                .ods       (ods_q[gi]),
                .ans       (ans_q[gi]),
                .pin_i     (pin_i[gi]),
                .pin_o_q   (pin_o[gi]),
                .pin_oe_q  (pin_oe[gi]),
                .ana_lvl_q (ana_lvl[gi]),
                .lvl_q     (lvl[gi])
            );
        end
    endgenerate

    // ****************************************
    // Checks
    // ****************************************
    // Setup cycle of a transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    // Access cycle, the one in which the transfer completes
    sequence s_access;
        psel && penable;
    endsequence
    // Setup followed at once by its access cycle
    sequence s_xfer;
        s_setup ##1 s_access;
    endsequence
    // Write access that lands in the output latch
    sequence s_lat_wr;
        wr && (hit_lat || hit_lvl);
    endsequence
    // Analog select starts all ones after reset
    ans_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> ans_q == GPCFG_RST_ANS)
        else $error("analog select not all ones");
    // Unmapped address flags an error
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !hit_any) |=> pslverr)
        else $error("unmapped access not flagged");
    // Level register read masks analog inputs
    lvl_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit_lvl) |=>
        (prdata[15:0] & $past(ans_q & dir_q)) == 16'h0000)
        else $error("analog input read back high");
    // Output latch write reaches pad two edges later
    lat_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_lat && !dir_q[0] && !ods_q[0]) |=> ##1 pin_o[0] == $past(pwdata[0], 2))
        else $error("latch not driven");

    // Direction write lands whole
    dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        we_dir |=> dir_q == $past(dir_d))
        else $error("direction write lost");

    // Latch write lands, from either latch or level offset
    lat_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_lat_wr |=> lat_q == $past(lat_d))
        else $error("latch write lost");

    // Open-drain write lands whole
    ods_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        we_ods |=> ods_q == $past(ods_d))
        else $error("open drain write lost");

    // Analog select write lands whole
    ans_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        we_ans |=> ans_q == $past(ans_d))
        else $error("analog select write lost");

    // Registers hold without a write
    regs_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr |=> $stable(dir_q) && $stable(lat_q) && $stable(ods_q) && $stable(ans_q))
        else $error("register changed without write");

    // Access completes in its first cycle
    ready_access_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_access |-> pready)
        else $error("access not answered");

    // Read data is the word selected at setup
    read_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_xfer |-> prdata[15:0] == $past(rd_mux))
        else $error("read data not from setup");

    // Upper half of read data stays zero
    upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_access |-> prdata[31:16] == 16'h0000)
        else $error("read upper half not zero");

    // Mapped offsets answer without error
    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit_any) |=> !pslverr)
        else $error("mapped access flagged");

    // Unmapped offsets read zero
    unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !hit_any) |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    // Direction and open-drain start at their defaults
    dir_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> dir_q == GPCFG_RST_DIR && ods_q == GPCFG_RST_ODS)
        else $error("direction or open drain not reset");

    // Input pins are never driven
    oe_inputs_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_oe & $past(dir_q)) == 16'h0000)
        else $error("input pin driven");

    // Open-drain pins drive low only
    od_low_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_oe & pin_o & $past(ods_q)) == 16'h0000)
        else $error("open drain pin drove high");

    // Push-pull outputs are always driven
    push_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
        (~$past(dir_q) & ~$past(ods_q) & ~pin_oe) == 16'h0000)
        else $error("push pull output released");

    // Analog peripherals only see analog output pins
    ana_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ana_lvl & ~($past(ans_q) & ~$past(dir_q))) == 16'h0000)
        else $error("analog level on digital pin");

    // Sampled level is low on analog inputs
    lvl_analog_a: assert property (@(posedge pclk) disable iff (!presetn)
        (lvl & $past(ans_q & dir_q)) == 16'h0000)
        else $error("analog input sampled high");

    // Sampled level follows the pad elsewhere
    lvl_digital_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((lvl ^ $past(pin_i)) & ~$past(ans_q & dir_q)) == 16'h0000)
        else $error("pad level not sampled");
endmodule
`default_nettype wire

// ### dv/gpcfg_pad_model.sv
// Pad model: external pull-up on every pin of the port
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pad_model
(
    input  wire logic [15:0] pin_o,   // Pad output values
    input  wire logic [15:0] pin_oe,  // Pad output enables
    output logic      [15:0] pin_i    // Resolved pad levels
);
    // Released pads float high through the pull-up
    assign pin_i = (pin_o & pin_oe) | ~pin_oe;
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking testbench of the port pin configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpcfg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] pin_i, pin_o, pin_oe, ana_lvl, ana_sel;
    int          miscompares, cmp_count;
    gpcfg_top gpcfg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .ana_lvl(ana_lvl), .ana_sel(ana_sel));
    gpcfg_pad_model gpcfg_pad_model_inst (.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
    // ****************************************
    // Bus cycle and compare helpers
    // ****************************************
    // One APB transfer; the request holds until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Pad samples lag a write by two edges, level samples by three, so wait three
    task settle();
        repeat (3) @(posedge pclk);
    endtask
    task tally_and_finish();
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset();
        apb(1'b0, GPCFG_OFF_ANS, 32'h0);
        chk("ans", 32'h0000FFFF, rd);
        apb(1'b0, GPCFG_OFF_ODS, 32'h0);
        chk("ods", 32'h00000000, rd);
        apb(1'b0, GPCFG_OFF_DIR, 32'h0);
        chk("dir", 32'h0000FFFF, rd);
        chk("ana_sel", 32'h0000FFFF, {16'h0, ana_sel});
        chk("oe", 32'h00000000, {16'h0, pin_oe});
        // Pads pulled high, yet analog inputs read low
        apb(1'b0, GPCFG_OFF_LVL, 32'h0);
        chk("lvl", 32'h00000000, rd);
    endtask
    task t_digital();
        apb(1'b1, GPCFG_OFF_ANS, 32'h0);
        apb(1'b1, GPCFG_OFF_DIR, 32'h0000FF00);
        apb(1'b1, GPCFG_OFF_LAT, 32'h000000A5);
        settle();
        chk("oe", 32'h000000FF, {16'h0, pin_oe});
        chk("out", 32'h000000A5, {16'h0, pin_o & pin_oe});
        apb(1'b0, GPCFG_OFF_LVL, 32'h0);
        chk("lvl", 32'h0000FFA5, rd);
        apb(1'b0, GPCFG_OFF_LAT, 32'h0);
        chk("lat", 32'h000000A5, rd);
    endtask
    task t_open_drain();
        apb(1'b1, GPCFG_OFF_ODS, 32'h0000000F);
        settle();
        chk("oe", 32'h000000FA, {16'h0, pin_oe});
        chk("low", 32'h00000000, {28'h0, pin_o[3:0] & pin_oe[3:0]});
        // Released open-drain pads read high through the pull-ups
        apb(1'b0, GPCFG_OFF_LVL, 32'h0);
        chk("lvl_od", 32'h0000FFA5, rd);
        apb(1'b0, GPCFG_OFF_ODS, 32'h0);
        chk("ods", 32'h0000000F, rd);
    endtask
    task t_analog_out();
        apb(1'b1, GPCFG_OFF_ODS, 32'h0);
        apb(1'b1, GPCFG_OFF_ANS, 32'h0000FFFF);
        apb(1'b1, GPCFG_OFF_DIR, 32'h0);
        apb(1'b1, GPCFG_OFF_LAT, 32'h00001234);
        settle();
        chk("ana_lvl", 32'h00001234, {16'h0, ana_lvl});
        chk("oe", 32'h0000FFFF, {16'h0, pin_oe});
        apb(1'b0, GPCFG_OFF_LVL, 32'h0);
        chk("lvl_ana_out", 32'h00001234, rd);
    endtask
    task t_level_write();
        // A write to the level offset lands in the latch
        apb(1'b1, GPCFG_OFF_LVL, 32'h00005A5A);
        apb(1'b0, GPCFG_OFF_LAT, 32'h0);
        chk("lat_via_lvl", 32'h00005A5A, rd);
        // Back to analog inputs: direction set beside analog select
        apb(1'b1, GPCFG_OFF_DIR, 32'h0000FFFF);
        settle();
        chk("oe_in", 32'h00000000, {16'h0, pin_oe});
        chk("ana_lvl_in", 32'h00000000, {16'h0, ana_lvl});
        apb(1'b0, GPCFG_OFF_LVL, 32'h0);
        chk("lvl_ana_in", 32'h00000000, rd);
    endtask
    task t_unmapped();
        apb(1'b1, 12'h014, 32'h0000FFFF);
        chk("wr_err", 32'h00000001, {31'h0, err});
        apb(1'b0, 12'h014, 32'h0);
        chk("rd", 32'h00000000, rd);
        chk("rd_err", 32'h00000001, {31'h0, err});
    endtask
    // ****************************************
    // Clock, reset, sequence and watchdog
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        miscompares = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_digital();
        t_open_drain();
        t_analog_out();
        t_level_write();
        t_unmapped();
        tally_and_finish();
    end
    // Whole run needs well under 200 cycles
    initial
    begin
        #(50 * 2000);
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
